// ---- inc/timer_pair_pkg.sv ----
// Package of register map, field layout and reset constants for the timer pair
package timer_pair_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_GLOBAL_IRQ = 8'h0B;
   localparam logic [7:0] OFF_IRQ_FLAGS = 8'h0C;
   localparam logic [7:0] OFF_WIDE_LOW = 8'h0E;
   localparam logic [7:0] OFF_WIDE_HIGH = 8'h0F;
   localparam logic [7:0] OFF_WIDE_CTRL = 8'h10;
   localparam logic [7:0] OFF_SHORT_COUNT = 8'h11;
   localparam logic [7:0] OFF_SHORT_CTRL = 8'h12;
   localparam logic [7:0] OFF_IRQ_ENABLES = 8'h8C;
   localparam logic [7:0] OFF_SHORT_PERIOD = 8'h92;
   localparam logic [7:0] OFF_COMPARE_LOW = 8'h15;
   localparam logic [7:0] OFF_COMPARE_HIGH = 8'h16;
   localparam logic [7:0] OFF_COMPARE_CTRL = 8'h17;
   localparam int BIT_WIDE_ON = 0;
   localparam int BIT_WIDE_SYNC_N = 2;
   localparam int BIT_AUX_OSC_EN = 3;
   localparam int BIT_WIDE_FLAG = 0;
   localparam int BIT_SHORT_FLAG = 1;
   localparam int BIT_SHORT_RUN = 2;
   localparam int PS_LSB = 0;
   localparam int POST_LSB = 3;
   localparam logic [7:0] WIDE_CTRL_MASK = 8'h3F;
   localparam logic [7:0] SHORT_CTRL_MASK = 8'h7F;
   localparam logic [7:0] FLAG_MASK = 8'h03;
   localparam logic [7:0] RESET_ZERO = 8'h00;
   localparam logic [7:0] RESET_PERIOD = 8'hFF;
   localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hB;
   localparam logic [1:0] PS_DIV1 = 2'h0;
   localparam logic [1:0] PS_DIV4 = 2'h1;
   localparam logic [3:0] PS_LAST_DIV1 = 4'h0;
   localparam logic [3:0] PS_LAST_DIV4 = 4'h3;
   localparam logic [3:0] PS_LAST_DIV16 = 4'hF;
   localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : timer_pair_pkg

// ---- rtl/short_prescaler.sv ----
// Prescaler of the short timer: one pulse per selected number of instruction ticks
`timescale 1ns/1ns
`default_nettype none
module short_prescaler
   import timer_pair_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic clear_in,
   input wire logic tick_in,
   input wire logic [1:0] sel_in,
   output logic pulse_out
);
   logic [3:0] count_reg;
   logic [3:0] last;

   always_comb begin
      unique case (sel_in)
         PS_DIV1: last = PS_LAST_DIV1;
         PS_DIV4: last = PS_LAST_DIV4;
         default: last = PS_LAST_DIV16;
      endcase
   end

   assign pulse_out = tick_in && !clear_in && (count_reg == last);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_reg <= 4'h0;
      end else if (clear_in) begin
         count_reg <= 4'h0;
      end else if (tick_in) begin
         count_reg <= (count_reg >= last) ? 4'h0 : count_reg + 4'h1;
      end
   end
endmodule // short_prescaler
`default_nettype wire

// ---- rtl/timer_pair.sv ----
// Wide and short timer pair with Avalon-MM register slave
`timescale 1ns/1ns
`default_nettype none
module timer_pair
   import timer_pair_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic [ADDR_W-1:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [7:0] writedata_in,
   output logic [7:0] readdata_out,
   output logic waitrequest_out,
   input wire logic sleep_in,
   input wire logic adc_enable_in,
   output logic aux_osc_run_out,
   output logic wide_irq_out,
   output logic short_irq_out,
   output logic adc_start_out
);
   logic rst_sync1_reg;
   logic rst_sync2_reg;
   logic rst_n;
   logic [1:0] instr_div_reg;
   logic instr_tick;
   logic [7:0] wide_ctrl_reg;
   logic [15:0] wide_count_reg;
   logic [15:0] compare_value_pair_reg;
   logic [7:0] compare_ctrl_reg;
   logic [7:0] global_ctrl_reg;
   logic [7:0] flags_reg;
   logic [7:0] enables_reg;
   logic [7:0] short_count_reg;
   logic [7:0] short_period_reg;
   logic [7:0] short_ctrl_reg;
   logic [3:0] post_count_reg;
   logic ack_reg;
   logic wr_stb;
   logic rd_stb;
   logic wide_tick;
   logic wide_wrap;
   logic special_event;
   logic short_clear;
   logic pre_pulse;
   logic short_match;
   logic post_done;
   logic [7:0] rd_mux;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_sync1_reg <= 1'b0;
         rst_sync2_reg <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_sync2_reg <= rst_sync1_reg;
      end
   end
   assign rst_n = rst_sync2_reg;

   // Bus strobes: one wait cycle, then ack
   assign wr_stb = write_in && ack_reg;
   assign rd_stb = read_in && ack_reg;

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (read_in || write_in) && !ack_reg;
      end
   end

   always_comb begin
      rd_mux = UNMAPPED_READ;
      if (hit(address_in, OFF_GLOBAL_IRQ)) rd_mux = global_ctrl_reg;
      if (hit(address_in, OFF_IRQ_FLAGS)) rd_mux = flags_reg & FLAG_MASK;
      if (hit(address_in, OFF_IRQ_ENABLES)) rd_mux = enables_reg & FLAG_MASK;
      if (hit(address_in, OFF_WIDE_LOW)) rd_mux = wide_count_reg[7:0];
      if (hit(address_in, OFF_WIDE_HIGH)) rd_mux = wide_count_reg[15:8];
      if (hit(address_in, OFF_WIDE_CTRL)) rd_mux = wide_ctrl_reg & WIDE_CTRL_MASK;
      if (hit(address_in, OFF_SHORT_COUNT)) rd_mux = short_count_reg;
      if (hit(address_in, OFF_SHORT_PERIOD)) rd_mux = short_period_reg;
      if (hit(address_in, OFF_SHORT_CTRL)) rd_mux = short_ctrl_reg & SHORT_CTRL_MASK;
      if (hit(address_in, OFF_COMPARE_LOW)) rd_mux = compare_value_pair_reg[7:0];
      if (hit(address_in, OFF_COMPARE_HIGH)) rd_mux = compare_value_pair_reg[15:8];
      if (hit(address_in, OFF_COMPARE_CTRL)) rd_mux = compare_ctrl_reg;
   end

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         readdata_out <= RESET_ZERO;
         waitrequest_out <= 1'b1;
      end else begin
         waitrequest_out <= !((read_in || write_in) && !ack_reg);
         if (read_in && !ack_reg) begin
            readdata_out <= rd_mux;
         end
      end
   end

   // Instruction clock: one tick per four master clocks
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         instr_div_reg <= 2'h0;
      end else begin
         instr_div_reg <= instr_div_reg + 2'h1;
      end
   end
   assign instr_tick = (instr_div_reg == INSTR_DIV_LAST);

   // Control registers
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         wide_ctrl_reg <= RESET_ZERO;
         short_ctrl_reg <= RESET_ZERO;
         short_period_reg <= RESET_PERIOD;
         compare_ctrl_reg <= RESET_ZERO;
         compare_value_pair_reg <= {RESET_PERIOD, RESET_PERIOD};
         global_ctrl_reg <= RESET_ZERO;
         enables_reg <= RESET_ZERO;
      end else if (wr_stb) begin
         if (hit(address_in, OFF_WIDE_CTRL)) wide_ctrl_reg <= writedata_in & WIDE_CTRL_MASK;
         if (hit(address_in, OFF_SHORT_CTRL)) short_ctrl_reg <= writedata_in & SHORT_CTRL_MASK;
         if (hit(address_in, OFF_SHORT_PERIOD)) short_period_reg <= writedata_in;
         if (hit(address_in, OFF_COMPARE_CTRL)) compare_ctrl_reg <= writedata_in;
         if (hit(address_in, OFF_COMPARE_LOW)) compare_value_pair_reg[7:0] <= writedata_in;
         if (hit(address_in, OFF_COMPARE_HIGH)) compare_value_pair_reg[15:8] <= writedata_in;
         if (hit(address_in, OFF_GLOBAL_IRQ)) global_ctrl_reg <= writedata_in;
         if (hit(address_in, OFF_IRQ_ENABLES)) enables_reg <= writedata_in & FLAG_MASK;
      end
   end

   // Aux oscillator enable, independent of sleep
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         aux_osc_run_out <= 1'b0;
      end else begin
         aux_osc_run_out <= wide_ctrl_reg[BIT_AUX_OSC_EN];
      end
   end

   // Wide counter: not reset, undefined at power-on
   assign wide_tick = instr_tick && wide_ctrl_reg[BIT_WIDE_ON];
   assign wide_wrap = wide_tick && (wide_count_reg == 16'hFFFF);
   // Special event only in synchronised mode (BIT_WIDE_SYNC_N clear)
   assign special_event = (compare_ctrl_reg[3:0] == MODE_SPECIAL_EVENT) && wide_tick
      && (wide_count_reg == compare_value_pair_reg) && !wide_ctrl_reg[BIT_WIDE_SYNC_N];

   always_ff @(posedge mclk_in) begin
      if (wr_stb && hit(address_in, OFF_WIDE_LOW)) begin
         wide_count_reg[7:0] <= writedata_in;
      end else if (wr_stb && hit(address_in, OFF_WIDE_HIGH)) begin
         wide_count_reg[15:8] <= writedata_in;
      end else if (special_event) begin
         wide_count_reg <= 16'h0000;
      end else if (wide_tick) begin
         wide_count_reg <= wide_count_reg + 16'h0001;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         adc_start_out <= 1'b0;
      end else begin
         adc_start_out <= special_event && adc_enable_in;
      end
   end

   // Short timer
   assign short_clear = wr_stb && (hit(address_in, OFF_SHORT_COUNT) || hit(address_in, OFF_SHORT_CTRL));

   short_prescaler u_pre (
      .clk_in(mclk_in),
      .rst_n_in(rst_n),
      .clear_in(short_clear),
      .tick_in(instr_tick && short_ctrl_reg[BIT_SHORT_RUN]),
      .sel_in(short_ctrl_reg[PS_LSB+1:PS_LSB]),
      .pulse_out(pre_pulse)
   );

   assign short_match = pre_pulse && (short_count_reg == short_period_reg);
   assign post_done = short_match && (post_count_reg == short_ctrl_reg[POST_LSB+3:POST_LSB]);

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         short_count_reg <= RESET_ZERO;
      end else if (wr_stb && hit(address_in, OFF_SHORT_COUNT)) begin
         short_count_reg <= writedata_in;
      end else if (short_match) begin
         short_count_reg <= RESET_ZERO;
      end else if (pre_pulse) begin
         short_count_reg <= short_count_reg + 8'h01;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         post_count_reg <= 4'h0;
      end else if (short_clear) begin
         post_count_reg <= 4'h0;
      end else if (post_done) begin
         post_count_reg <= 4'h0;
      end else if (short_match) begin
         post_count_reg <= post_count_reg + 4'h1;
      end
   end

   // Flags: hardware set wins over software clear
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         flags_reg <= RESET_ZERO;
      end else begin
         if (wr_stb && hit(address_in, OFF_IRQ_FLAGS)) begin
            flags_reg <= (writedata_in & FLAG_MASK)
               | {6'h00, post_done, wide_wrap && !special_event};
         end else begin
            flags_reg[BIT_WIDE_FLAG] <= flags_reg[BIT_WIDE_FLAG] | (wide_wrap && !special_event);
            flags_reg[BIT_SHORT_FLAG] <= flags_reg[BIT_SHORT_FLAG] | post_done;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         wide_irq_out <= 1'b0;
         short_irq_out <= 1'b0;
      end else begin
         wide_irq_out <= flags_reg[BIT_WIDE_FLAG] && enables_reg[BIT_WIDE_FLAG];
         short_irq_out <= flags_reg[BIT_SHORT_FLAG] && enables_reg[BIT_SHORT_FLAG];
      end
   end

   a_irq_gate: assert property (@(posedge mclk_in) disable iff (!rst_n)
      wide_irq_out |-> $past(enables_reg[BIT_WIDE_FLAG])) else $error("wide irq without enable");
   a_flag_sticky: assert property (@(posedge mclk_in) disable iff (!rst_n)
      $rose(flags_reg[BIT_SHORT_FLAG]) |-> $past(post_done) || $past(wr_stb && writedata_in[BIT_SHORT_FLAG]))
      else $error("short flag without match");
   a_event_clear: assert property (@(posedge mclk_in) disable iff (!rst_n)
      (special_event && !wr_stb) |=> wide_count_reg == 16'h0000) else $error("special event not cleared");
   a_event_noflag: assert property (@(posedge mclk_in) disable iff (!rst_n)
      (special_event && !flags_reg[BIT_WIDE_FLAG] && !wr_stb) |=> !flags_reg[BIT_WIDE_FLAG])
      else $error("special event set overflow flag");
   a_wrap_flag: assert property (@(posedge mclk_in) disable iff (!rst_n)
      (wide_wrap && !special_event) |=> flags_reg[BIT_WIDE_FLAG]) else $error("wrap lost");
   a_short_stop: assert property (@(posedge mclk_in) disable iff (!rst_n)
      (!short_ctrl_reg[BIT_SHORT_RUN] && !wr_stb) |=> $stable(short_count_reg)) else $error("short ran while off");
   a_short_wrap: assert property (@(posedge mclk_in) disable iff (!rst_n)
      (short_match && !wr_stb) |=> short_count_reg == RESET_ZERO) else $error("short not restarted");
   a_ctrl_bit7: assert property (@(posedge mclk_in) disable iff (!rst_n)
      !short_ctrl_reg[7]) else $error("short control bit7 set");
   a_osc_follow: assert property (@(posedge mclk_in) disable iff (!rst_n)
      aux_osc_run_out == $past(wide_ctrl_reg[BIT_AUX_OSC_EN])) else $error("oscillator enable mismatch");
   a_wide_step: assert property (@(posedge mclk_in) disable iff (!rst_n)
      (wide_tick && !special_event && !wr_stb) |=> wide_count_reg == $past(wide_count_reg) + 16'h0001)
      else $error("wide counter did not step");
   a_wrap_zero: assert property (@(posedge mclk_in) disable iff (!rst_n)
      (wide_wrap && !wr_stb) |=> wide_count_reg == 16'h0000) else $error("wide counter did not wrap");
   a_adc_gate: assert property (@(posedge mclk_in) disable iff (!rst_n)
      adc_start_out |-> $past(adc_enable_in)) else $error("conversion start while converter off");
   a_scaler_clear: assert property (@(posedge mclk_in) disable iff (!rst_n)
      short_clear |=> (post_count_reg == 4'h0) && (u_pre.count_reg == 4'h0))
      else $error("scalers not cleared");
   a_ctrl_keeps: assert property (@(posedge mclk_in) disable iff (!rst_n)
      (wr_stb && hit(address_in, OFF_SHORT_CTRL)) |=> $stable(short_count_reg)) else $error("control write moved count");
   a_post_step: assert property (@(posedge mclk_in) disable iff (!rst_n)
      (short_match && !post_done && !short_clear) |=> post_count_reg == $past(post_count_reg) + 4'h1)
      else $error("postscaler did not step");
   a_short_step: assert property (@(posedge mclk_in) disable iff (!rst_n)
      (pre_pulse && !short_match && !wr_stb) |=> short_count_reg == $past(short_count_reg) + 8'h01)
      else $error("short counter did not step");
   a_irq_short: assert property (@(posedge mclk_in) disable iff (!rst_n)
      short_irq_out |-> $past(enables_reg[BIT_SHORT_FLAG])) else $error("short irq without enable");
   a_flag_hold: assert property (@(posedge mclk_in) disable iff (!rst_n)
      (flags_reg[BIT_WIDE_FLAG] && !wr_stb) |=> flags_reg[BIT_WIDE_FLAG]) else $error("overflow flag lost");
   a_short_hold: assert property (@(posedge mclk_in) disable iff (!rst_n)
      (flags_reg[BIT_SHORT_FLAG] && !wr_stb) |=> flags_reg[BIT_SHORT_FLAG]) else $error("short flag lost");
   a_bus_wait: assert property (@(posedge mclk_in) disable iff (!rst_n)
      !waitrequest_out |=> waitrequest_out) else $error("wait released twice");
   a_read_answer: assert property (@(posedge mclk_in) disable iff (!rst_n)
      rd_stb |-> !waitrequest_out) else $error("read taken without answer");

   // Scenarios worth seeing
   c_wrap: cover property (@(posedge mclk_in) disable iff (!rst_n) wide_wrap);
   c_event: cover property (@(posedge mclk_in) disable iff (!rst_n) special_event);
   c_post: cover property (@(posedge mclk_in) disable iff (!rst_n) post_done);
   c_sleep_osc: cover property (@(posedge mclk_in) disable iff (!rst_n) sleep_in && aux_osc_run_out);
   c_conv_gated: cover property (@(posedge mclk_in) disable iff (!rst_n) special_event && !adc_enable_in);
endmodule // timer_pair
`default_nettype wire

// ---- tb/host_partner.sv ----
// Processor-side partner: sleep and converter enable, counts conversion starts
`timescale 1ns/1ns
`default_nettype none
module host_partner (
   input wire logic clk_in,
   input wire logic sleep_req_in,
   input wire logic conv_req_in,
   input wire logic conv_start_in,
   output logic sleep_out,
   output logic conv_enable_out,
   output int starts_out
);
   logic sleep_q = 1'b0;
   logic conv_q = 1'b0;
   int count_q = 0;
   assign sleep_out = sleep_q;
   assign conv_enable_out = conv_q;
   assign starts_out = count_q;
   always @(posedge clk_in) begin
      sleep_q <= sleep_req_in;
      conv_q <= conv_req_in;
      if (conv_start_in === 1'b1) begin
         count_q <= count_q + 1;
      end
   end
endmodule // host_partner
`default_nettype wire

// ---- tb/test_timer_pair.sv ----
// Self-checking bench of the timer pair through its register bus
`timescale 1ns/1ns
`default_nettype none
module test_timer_pair;
   import timer_pair_pkg::*;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [ADDR_W-1:0] address_in = '0;
   logic read_in = 1'b0;
   logic write_in = 1'b0;
   logic [7:0] writedata_in = 8'h00;
   logic [7:0] readdata_out;
   logic waitrequest_out, sleep_in, adc_enable_in, aux_osc_run_out, wide_irq_out, short_irq_out, adc_start_out;
   logic sleep_req = 1'b0;
   logic conv_req = 1'b1;
   int starts;
   int num_errors = 0;
   int n_compared = 0;
   timer_pair uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .address_in(address_in), .read_in(read_in),
      .write_in(write_in), .writedata_in(writedata_in), .readdata_out(readdata_out),
      .waitrequest_out(waitrequest_out), .sleep_in(sleep_in), .adc_enable_in(adc_enable_in),
      .aux_osc_run_out(aux_osc_run_out), .wide_irq_out(wide_irq_out), .short_irq_out(short_irq_out),
      .adc_start_out(adc_start_out));
   host_partner partner (.clk_in(mclk_in), .sleep_req_in(sleep_req), .conv_req_in(conv_req),
      .conv_start_in(adc_start_out), .sleep_out(sleep_in), .conv_enable_out(adc_enable_in), .starts_out(starts));
   initial begin
      forever #5 mclk_in = ~mclk_in;
   end
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      address_in <= a;
      writedata_in <= d;
      write_in <= wr;
      read_in <= !wr;
      @(posedge mclk_in);
      while (waitrequest_out !== 1'b0) begin
         @(posedge mclk_in);
      end
      q = readdata_out;
      write_in <= 1'b0;
      read_in <= 1'b0;
      @(posedge mclk_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      check(what, {8'h00, q}, {8'h00, exp});
   endtask
   task automatic t_reset;
      rd_chk("short_ctrl", OFF_SHORT_CTRL, RESET_ZERO);
      rd_chk("short_period", OFF_SHORT_PERIOD, RESET_PERIOD);
      rd_chk("short_count", OFF_SHORT_COUNT, RESET_ZERO);
      rd_chk("flags", OFF_IRQ_FLAGS, RESET_ZERO);
      rd_chk("enables", OFF_IRQ_ENABLES, RESET_ZERO);
      rd_chk("wide_ctrl", OFF_WIDE_CTRL, RESET_ZERO);
      wr(OFF_SHORT_CTRL, 8'hFF);
      rd_chk("short_ctrl_b7", OFF_SHORT_CTRL, 8'h7F);
      wr(OFF_SHORT_CTRL, 8'h00);
      wr(8'h40, 8'h5A);
      rd_chk("unmapped", 8'h40, UNMAPPED_READ);
      $display("test reset done");
   endtask
   task automatic t_osc;
      wr(OFF_WIDE_CTRL, 8'h08);
      sleep_req <= 1'b1;
      repeat (4) @(posedge mclk_in);
      check("osc_in_sleep", aux_osc_run_out, 16'h0001);
      wr(OFF_WIDE_CTRL, 8'h00);
      repeat (2) @(posedge mclk_in);
      check("osc_off", aux_osc_run_out, 16'h0000);
      sleep_req <= 1'b0;
      $display("test osc done");
   endtask
   task automatic t_wrap;
      wr(OFF_WIDE_LOW, 8'hFE);
      wr(OFF_WIDE_HIGH, 8'hFF);
      wr(OFF_IRQ_FLAGS, 8'h00);
      wr(OFF_IRQ_ENABLES, 8'h01);
      wr(OFF_WIDE_CTRL, 8'h01);
      repeat (20) @(posedge mclk_in);
      rd_chk("wrap_flag", OFF_IRQ_FLAGS, 8'h01);
      rd_chk("wrap_high", OFF_WIDE_HIGH, 8'h00);
      check("wide_irq_on", wide_irq_out, 16'h0001);
      wr(OFF_IRQ_ENABLES, 8'h00);
      repeat (3) @(posedge mclk_in);
      check("wide_irq_off", wide_irq_out, 16'h0000);
      rd_chk("flag_held", OFF_IRQ_FLAGS, 8'h01);
      wr(OFF_WIDE_CTRL, 8'h00);
      wr(OFF_IRQ_FLAGS, 8'h00);
      $display("test wrap done");
   endtask
   task automatic t_event;
      int n;
      wr(OFF_WIDE_LOW, 8'h00);
      wr(OFF_WIDE_HIGH, 8'h00);
      wr(OFF_COMPARE_LOW, 8'h10);
      wr(OFF_COMPARE_HIGH, 8'h00);
      wr(OFF_COMPARE_CTRL, {4'h0, MODE_SPECIAL_EVENT});
      wr(OFF_WIDE_CTRL, 8'h01);
      n = 0;
      while (adc_start_out !== 1'b1 && n < 200) begin
         @(posedge mclk_in);
         n++;
      end
      check("event_seen", n < 200, 16'h0001);
      n = 0;
      do begin
         @(posedge mclk_in);
         n++;
      end while (adc_start_out !== 1'b1 && n < 200);
      check("event_period", n[15:0], 16'h0044);
      rd_chk("no_flag", OFF_IRQ_FLAGS, 8'h00);
      check("conv_starts", starts[15:0], 16'h0002);
      conv_req <= 1'b0;
      repeat (80) @(posedge mclk_in);
      check("conv_gated", starts[15:0], 16'h0002);
      wr(OFF_WIDE_CTRL, 8'h00);
      wr(OFF_COMPARE_CTRL, 8'h00);
      $display("test event done");
   endtask
   task automatic t_keep;
      wr(OFF_WIDE_LOW, 8'h34);
      wr(OFF_WIDE_HIGH, 8'h12);
      wr(OFF_SHORT_PERIOD, 8'h21);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      rd_chk("keep_low", OFF_WIDE_LOW, 8'h34);
      rd_chk("keep_high", OFF_WIDE_HIGH, 8'h12);
      rd_chk("period_reset", OFF_SHORT_PERIOD, RESET_PERIOD);
      $display("test keep done");
   endtask
   task automatic t_short;
      int div[4] = '{1, 4, 16, 16};
      logic [3:0] post[4] = '{4'h0, 4'h1, 4'hF, 4'h7};
      int span;
      wr(OFF_SHORT_PERIOD, 8'h07);
      rd_chk("period_rw", OFF_SHORT_PERIOD, 8'h07);
      wr(OFF_IRQ_ENABLES, 8'h02);
      for (int i = 0; i < 4; i++) begin
         span = 4 * div[i] * 8 * (post[i] + 1);
         wr(OFF_SHORT_CTRL, 8'h00);
         wr(OFF_SHORT_COUNT, 8'h00);
         wr(OFF_IRQ_FLAGS, 8'h00);
         wr(OFF_SHORT_CTRL, {1'b0, post[i], 1'b1, i[1:0]});
         repeat (span / 2) @(posedge mclk_in);
         rd_chk("short_early", OFF_IRQ_FLAGS, 8'h00);
         repeat (span * 3 / 4) @(posedge mclk_in);
         rd_chk("short_flag", OFF_IRQ_FLAGS, 8'h02);
         check("short_irq", short_irq_out, 16'h0001);
      end
      wr(OFF_SHORT_CTRL, 8'h00);
      wr(OFF_SHORT_COUNT, 8'h05);
      wr(OFF_SHORT_CTRL, 8'h00);
      repeat (100) @(posedge mclk_in);
      rd_chk("stopped", OFF_SHORT_COUNT, 8'h05);
      rd_chk("flag_sticky", OFF_IRQ_FLAGS, 8'h02);
      wr(OFF_IRQ_FLAGS, 8'h00);
      rd_chk("flag_cleared", OFF_IRQ_FLAGS, 8'h00);
      $display("test short done");
   endtask
   initial begin
      repeat (10) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      t_reset();
      t_osc();
      t_wrap();
      t_event();
      t_keep();
      t_short();
      report_and_stop();
   end
   initial begin
      repeat (60000) @(posedge mclk_in);
      num_errors++;
      report_and_stop();
   end
endmodule // test_timer_pair
`default_nettype wire
